// ### design/scc_converter_control.sv
// Control logic, registers and clocking of the 10-bit SAR converter
// Behaviour
// R1: Ten-bit result by successive approximation, kept in high and low bytes.
// R2: Channel select routes one of seven sources to sample-and-hold.
// R3: Software waits an acquisition delay after changing channel.
// R4: Positive reference is pin or supply; negative is always ground.
// R5: Clock select decodes six core dividers and the internal RC oscillator.
// R6: Bit period is one conversion clock; conversion lasts 11.5 periods.
// R7: Divider clocks follow core clock; only RC clock is independent.
// R8: Done flag set at every completion, whatever the interrupt enable.
// R9: Software clears the done flag; hardware never clears it.
// R10: Converter runs in sleep only with the RC clock selected.
// R11: Enabled completion in sleep wakes the core; next instruction runs.
// R12: Wake resumes in line without global enable, else enters ISR.
// R13: Temperature indicator powered only while its enable bit is set.
// R14: Range bit set selects high range, clear selects low range.
// R15: Software waits 200 us after routing temperature to the input.
// R16: Software leaves 200 us between temperature conversions.
// R17: Temperature indicator reaches the converter on a dedicated channel.
// R18: Codes 0-3 pins, 1d temperature, 1e DAC, 1f reference; rest open.
// R19: Go bit starts; completion clears it, sets flag, loads results.
// R20: Enable bit powers the converter; cleared means no current.
// R21: Right justified result loads six zero bits atop the high byte.
// R22: RC-timed completion is synchronised before any register update.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module scc_converter_control (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        CORE_SLEEP,
    input  wire logic        RC_OSC_IN,
    input  wire logic        COMP_OUT,
    output logic             CONV_POWER,
    output logic             SAMPLE_HOLD,
    output logic [9:0]       TRIAL_CODE,
    output logic [6:0]       CHANNEL_ROUTE,
    output logic             REF_FROM_PIN,
    output logic             TEMP_SENSE_POWER,
    output logic             TEMP_RANGE_HIGH,
    output logic             FIXED_REF_POWER,
    output logic [1:0]       COMP_REF_GAIN,
    output logic [1:0]       CONV_REF_GAIN,
    output logic             CONV_IRQ,
    output logic             WAKE_REQ,
    output logic             WAKE_TO_ISR
);
    import scc_pkg::*;

    // Bus handshake
    logic        ack;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;

    // Register contents
    logic [4:0]  input_channel_select;
    logic        go;
    logic        converter_enable;
    logic        result_format_select;
    logic [2:0]  conv_clock_select;
    logic [1:0]  positive_ref_select;
    logic [7:0]  result_high;
    logic [7:0]  result_low;
    logic        fixed_reference_on;
    logic        temp_sense_on;
    logic        temp_range_select;
    logic [1:0]  comp_gain;
    logic [1:0]  conv_gain;
    logic        conv_done_flag;
    logic        conv_int_enable;
    logic        peripheral_int_enable;
    logic        global_int_enable;

    // Synchronisers and timing
    logic        comp_meta;
    logic        comp_sync;
    logic        rc_meta;
    logic        rc_sync;
    logic        rc_prev;
    logic        use_rc;
    logic [4:0]  half_len;
    logic [4:0]  div_cnt;
    logic        half_tick;

    // Conversion control
    logic        busy;
    logic        done;
    logic [9:0]  raw_result;
    logic        start;
    logic        soft_stop;
    logic        sleep_stop;
    logic        abort;
    scc_end_t    end_kind;
    logic        complete;
    logic        off_in_sleep;
    logic        wake_armed;

    assign wbyte = AVS_WRITEDATA[7:0];
    assign wr_en = AVS_WRITE && ack && AVS_BYTEENABLE[0];
    // One wait cycle per access; the request is acted on when it ends
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack <= 1'b0;
        end else begin
            ack <= (AVS_READ || AVS_WRITE) && !ack;
        end
    end

    always_comb begin
        rbyte = RST_BYTE;
        if (AVS_ADDRESS == OFS_CTRL0) begin
            rbyte = {1'b0, input_channel_select, go, converter_enable};
        end else if (AVS_ADDRESS == OFS_CTRL1) begin
            rbyte = {result_format_select, conv_clock_select, 2'b00,
                     positive_ref_select};
        end else if (AVS_ADDRESS == OFS_RES_HI) begin
            rbyte = result_high;
        end else if (AVS_ADDRESS == OFS_RES_LO) begin
            rbyte = result_low;
        end else if (AVS_ADDRESS == OFS_VREF) begin
            rbyte = {fixed_reference_on, fixed_reference_on, temp_sense_on,
                     temp_range_select, comp_gain, conv_gain};
        end else if (AVS_ADDRESS == OFS_FLAGS) begin
            rbyte[FLAG_DONE] = conv_done_flag;
        end else if (AVS_ADDRESS == OFS_ENABLES) begin
            rbyte[IE_DONE] = conv_int_enable;
        end else if (AVS_ADDRESS == OFS_INTCTL) begin
            rbyte[INT_GIE]  = global_int_enable;
            rbyte[INT_PERIPHERAL_INT_ENABLE] = peripheral_int_enable;
        end
    end

    // Read data held from the wait cycle through the accepting edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack) begin
            AVS_READDATA <= {24'h00_0000, rbyte};
        end
    end

    // Comparator and RC oscillator arrive asynchronously
    always_ff @(posedge CLK) begin
        if (RST) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            rc_meta   <= 1'b0;
            rc_sync   <= 1'b0;
            rc_prev   <= 1'b0;
        end else begin
            comp_meta <= COMP_OUT;
            comp_sync <= comp_meta;
            rc_meta   <= RC_OSC_IN; // R22
            rc_sync   <= rc_meta;
            rc_prev   <= rc_sync;
        end
    end

    assign use_rc = (conv_clock_select[1:0] == CS_RC); // R5

    always_comb begin
        case (conv_clock_select) // R5
            CS_DIV2:  half_len = HALF_DIV2;
            CS_DIV4:  half_len = HALF_DIV4;
            CS_DIV8:  half_len = HALF_DIV8;
            CS_DIV16: half_len = HALF_DIV16;
            CS_DIV32: half_len = HALF_DIV32;
            CS_DIV64: half_len = HALF_DIV64;
            default:  half_len = HALF_DIV2;
        endcase
    end

    // Divider counts core clocks, so its rate tracks the core clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_cnt <= 5'd0;
        end else if (!busy || half_tick) begin
            div_cnt <= 5'd0; // R7
        end else begin
            div_cnt <= div_cnt + 5'd1;
        end
    end

    // Each RC edge is half a bit period; both edges count
    assign half_tick = use_rc ? (rc_sync != rc_prev) // R6
                              : busy && (div_cnt == half_len - 5'd1); // R6

    assign start = wr_en && (AVS_ADDRESS == OFS_CTRL0) && wbyte[CTRL0_GO]
                   && converter_enable && !busy && !sleep_stop; // R19
    assign soft_stop = wr_en && (AVS_ADDRESS == OFS_CTRL0)
                       && !wbyte[CTRL0_GO] && busy;
    assign sleep_stop = CORE_SLEEP && !use_rc; // R10
    assign abort = soft_stop || (sleep_stop && busy) // R10
                   || (busy && !converter_enable); // R20
    assign complete = done && (end_kind == SCC_END_NORMAL);

    scc_sar_engine u_sar (
        .clk       (CLK),
        .rst       (RST),
        .start     (start),
        .abort     (abort),
        .half_tick (half_tick),
        .comp      (comp_sync),
        .busy      (busy),
        .done      (done),
        .result    (raw_result),
        .trial     (TRIAL_CODE),
        .sample    (SAMPLE_HOLD)
    );

    // Remember how the running conversion is to end
    always_ff @(posedge CLK) begin
        if (RST) begin
            end_kind <= SCC_END_NORMAL;
        end else if (start) begin
            end_kind <= SCC_END_NORMAL;
        end else if (busy && (sleep_stop || !converter_enable)) begin
            end_kind <= SCC_END_SLEEP;
        end else if (busy && soft_stop) begin
            end_kind <= SCC_END_SOFT;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            input_channel_select <= RST_CHS;
            converter_enable     <= 1'b0;
            go                   <= 1'b0;
        end else begin
            if (wr_en && (AVS_ADDRESS == OFS_CTRL0)) begin
                input_channel_select <= wbyte[CTRL0_CHS_LO +: 5]; // R2
                converter_enable     <= wbyte[CTRL0_ON]; // R20
                go                   <= start || (wbyte[CTRL0_GO] && busy);
            end else if (done || (busy && sleep_stop)) begin
                go <= 1'b0; // R19
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            result_format_select <= 1'b0;
            conv_clock_select    <= RST_CS;
            positive_ref_select  <= RST_PREF;
        end else if (wr_en && (AVS_ADDRESS == OFS_CTRL1)) begin
            result_format_select <= wbyte[CTRL1_FM];
            conv_clock_select    <= wbyte[CTRL1_CS_LO +: 3];
            positive_ref_select  <= wbyte[CTRL1_PREF +: 2];
        end
    end

    // A sleep abort leaves the old result in place
    always_ff @(posedge CLK) begin
        if (RST) begin
            result_high <= RST_BYTE;
            result_low  <= RST_BYTE;
        end else if (done && end_kind != SCC_END_SLEEP) begin
            if (result_format_select) begin
                result_high <= {6'b00_0000, raw_result[9:8]}; // R21
                result_low  <= raw_result[7:0];
            end else begin
                result_high <= raw_result[9:2]; // R1
                result_low  <= {raw_result[1:0], 6'b00_0000};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            fixed_reference_on <= 1'b0;
            temp_sense_on      <= 1'b0;
            temp_range_select  <= 1'b0;
            comp_gain          <= RST_GAIN;
            conv_gain          <= RST_GAIN;
        end else if (wr_en && (AVS_ADDRESS == OFS_VREF)) begin
            fixed_reference_on <= wbyte[VREF_FIXED_REFERENCE_ON];
            temp_sense_on      <= wbyte[VREF_TEMP_SENSE_ON]; // R13
            temp_range_select  <= wbyte[VREF_TEMP_RANGE_SELECT]; // R14
            comp_gain          <= wbyte[VREF_CD_LO +: 2];
            conv_gain          <= wbyte[VREF_AD_LO +: 2];
        end
    end

    // Completion sets the flag even if a clearing write lands alongside
    always_ff @(posedge CLK) begin
        if (RST) begin
            conv_done_flag <= 1'b0;
        end else if (complete) begin
            conv_done_flag <= 1'b1; // R8
        end else if (wr_en && (AVS_ADDRESS == OFS_FLAGS)) begin
            conv_done_flag <= wbyte[FLAG_DONE]; // R9
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            conv_int_enable       <= 1'b0;
            peripheral_int_enable <= 1'b0;
            global_int_enable     <= 1'b0;
        end else begin
            if (wr_en && (AVS_ADDRESS == OFS_ENABLES)) begin
                conv_int_enable <= wbyte[IE_DONE];
            end
            if (wr_en && (AVS_ADDRESS == OFS_INTCTL)) begin
                peripheral_int_enable <= wbyte[INT_PERIPHERAL_INT_ENABLE];
                global_int_enable     <= wbyte[INT_GIE];
            end
        end
    end

    // Without an enabled interrupt the converter powers down after a
    // sleep conversion, though the enable bit stays set
    always_ff @(posedge CLK) begin
        if (RST) begin
            off_in_sleep <= 1'b0;
        end else if (!CORE_SLEEP) begin
            off_in_sleep <= 1'b0;
        end else if (complete && !conv_int_enable) begin
            off_in_sleep <= 1'b1;
        end
    end

    assign wake_armed = conv_int_enable && peripheral_int_enable;

    always_ff @(posedge CLK) begin
        if (RST) begin
            WAKE_REQ    <= 1'b0;
            WAKE_TO_ISR <= 1'b0;
        end else begin
            WAKE_REQ <= CORE_SLEEP && complete && wake_armed; // R11
            if (CORE_SLEEP && complete && wake_armed) begin
                WAKE_TO_ISR <= global_int_enable; // R12
            end else if (!CORE_SLEEP) begin
                WAKE_TO_ISR <= 1'b0;
            end
        end
    end

    // Decoded analog controls, registered to keep them glitch free
    for (genvar i = 0; i < 4; i++) begin : g_pin_route
        always_ff @(posedge CLK) begin
            if (RST) begin
                CHANNEL_ROUTE[i] <= 1'b0;
            end else begin
                CHANNEL_ROUTE[i] <= (input_channel_select == 5'(i)); // R18
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            CHANNEL_ROUTE[6:4] <= 3'b000;
            REF_FROM_PIN       <= 1'b0;
            CONV_POWER         <= 1'b0;
            TEMP_SENSE_POWER   <= 1'b0;
            TEMP_RANGE_HIGH    <= 1'b0;
            FIXED_REF_POWER    <= 1'b0;
            COMP_REF_GAIN      <= RST_GAIN;
            CONV_REF_GAIN      <= RST_GAIN;
            CONV_IRQ           <= 1'b0;
        end else begin
            CHANNEL_ROUTE[4] <= (input_channel_select == CH_TEMP); // R17
            CHANNEL_ROUTE[5] <= (input_channel_select == CH_DAC); // R2
            CHANNEL_ROUTE[6] <= (input_channel_select == CH_FVR); // R2
            REF_FROM_PIN     <= (positive_ref_select == 2'b10); // R4
            CONV_POWER       <= converter_enable && !off_in_sleep
                                && !sleep_stop; // R20
            TEMP_SENSE_POWER <= temp_sense_on; // R13
            TEMP_RANGE_HIGH  <= temp_range_select; // R14
            FIXED_REF_POWER  <= fixed_reference_on;
            COMP_REF_GAIN    <= comp_gain;
            CONV_REF_GAIN    <= conv_gain;
            CONV_IRQ         <= conv_done_flag && conv_int_enable
                                && peripheral_int_enable
                                && global_int_enable; // R12
        end
    end

endmodule : scc_converter_control

// ### design/scc_pkg.sv
// Constants and types shared by the converter control design
package scc_pkg;

    localparam int RES_BITS = 10;

    // Register word indices on the bus
    localparam logic [3:0] OFS_CTRL0   = 4'h0;
    localparam logic [3:0] OFS_CTRL1   = 4'h1;
    localparam logic [3:0] OFS_RES_HI  = 4'h2;
    localparam logic [3:0] OFS_RES_LO  = 4'h3;
    localparam logic [3:0] OFS_VREF    = 4'h4;
    localparam logic [3:0] OFS_FLAGS   = 4'h5;
    localparam logic [3:0] OFS_ENABLES = 4'h6;
    localparam logic [3:0] OFS_INTCTL  = 4'h7;

    // converter_control_0 fields
    localparam int CTRL0_ON     = 0;
    localparam int CTRL0_GO     = 1;
    localparam int CTRL0_CHS_LO = 2;
    // converter_control_1 fields
    localparam int CTRL1_PREF   = 0;
    localparam int CTRL1_CS_LO  = 4;
    localparam int CTRL1_FM     = 7;
    // voltage_ref_temp_control fields
    localparam int VREF_AD_LO   = 0;
    localparam int VREF_CD_LO   = 2;
    localparam int VREF_TEMP_RANGE_SELECT   = 4;
    localparam int VREF_TEMP_SENSE_ON    = 5;
    localparam int VREF_RDY     = 6;
    localparam int VREF_FIXED_REFERENCE_ON   = 7;
    // Flag, enable and interrupt control fields
    localparam int FLAG_DONE    = 6;
    localparam int IE_DONE      = 6;
    localparam int INT_PERIPHERAL_INT_ENABLE     = 6;
    localparam int INT_GIE      = 7;

    // Reset values
    localparam logic [4:0] RST_CHS   = 5'h00;
    localparam logic [2:0] RST_CS    = 3'h0;
    localparam logic [1:0] RST_PREF  = 2'h0;
    localparam logic [1:0] RST_GAIN  = 2'h0;
    localparam logic [9:0] RST_RES   = 10'h000;
    localparam logic [7:0] RST_BYTE  = 8'h00;

    // Channel codes
    localparam logic [4:0] CH_PIN_LAST = 5'h03;
    localparam logic [4:0] CH_TEMP     = 5'h1d;
    localparam logic [4:0] CH_DAC      = 5'h1e;
    localparam logic [4:0] CH_FVR      = 5'h1f;

    // Conversion clock select codes
    localparam logic [2:0] CS_DIV2  = 3'h0;
    localparam logic [2:0] CS_DIV4  = 3'h4;
    localparam logic [2:0] CS_DIV8  = 3'h1;
    localparam logic [2:0] CS_DIV16 = 3'h5;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h6;
    localparam logic [1:0] CS_RC    = 2'h3;

    // Half bit-period lengths in core clocks, one per divider
    localparam logic [4:0] HALF_DIV2  = 5'd1;
    localparam logic [4:0] HALF_DIV4  = 5'd2;
    localparam logic [4:0] HALF_DIV8  = 5'd4;
    localparam logic [4:0] HALF_DIV16 = 5'd8;
    localparam logic [4:0] HALF_DIV32 = 5'd16;
    localparam logic [4:0] HALF_DIV64 = 5'd0; // 32 wraps; count ends at 31

    // 11.5 bit periods: 3 half periods of sampling, then 2 per bit
    localparam logic [1:0] SAMPLE_HALVES = 2'd3;

    typedef enum logic [2:0] {
        SCC_IDLE = 3'b001,
        SCC_ACQ  = 3'b010,
        SCC_BITS = 3'b100
    } scc_state_t;

    typedef enum logic [1:0] {
        SCC_END_NORMAL = 2'b00,
        SCC_END_SOFT   = 2'b01,
        SCC_END_SLEEP  = 2'b10
    } scc_end_t;

endpackage : scc_pkg

// ### design/scc_sar_engine.sv
// Successive approximation sequencer driven by half bit-period ticks
`timescale 1ns/100ps
module scc_sar_engine (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    start,
    input  wire logic                    abort,
    input  wire logic                    half_tick,
    input  wire logic                    comp,
    output logic                         busy,
    output logic                         done,
    output logic [scc_pkg::RES_BITS-1:0] result,
    output logic [scc_pkg::RES_BITS-1:0] trial,
    output logic                         sample
);
    import scc_pkg::*;

    scc_state_t          state;
    logic [1:0]          acq_cnt;
    logic                phase;
    logic [3:0]          idx;
    logic [RES_BITS-1:0] decided;
    logic                last_bit;
    logic                finishing;
    logic [RES_BITS-1:0] next_result;
    logic [RES_BITS-1:0] next_trial;

    assign busy      = (state != SCC_IDLE);
    assign finishing = (state == SCC_BITS) && !abort && half_tick && phase
                       && (idx == 4'd0);

    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= SCC_IDLE;
            acq_cnt  <= 2'd0;
            phase    <= 1'b0;
            idx      <= 4'(RES_BITS - 1);
            decided  <= RST_RES;
            last_bit <= 1'b0;
        end else begin
            case (state)
                SCC_IDLE: begin
                    if (start) begin
                        state    <= SCC_ACQ;
                        acq_cnt  <= 2'd0;
                        phase    <= 1'b0;
                        idx      <= 4'(RES_BITS - 1);
                        decided  <= RST_RES;
                        last_bit <= 1'b0;
                    end
                end
                SCC_ACQ: begin
                    if (abort) begin
                        state <= SCC_IDLE;
                    end else if (half_tick) begin
                        if (acq_cnt == SAMPLE_HALVES - 2'd1) begin
                            state <= SCC_BITS;
                        end else begin
                            acq_cnt <= acq_cnt + 2'd1;
                        end
                    end
                end
                SCC_BITS: begin
                    if (abort) begin
                        state <= SCC_IDLE;
                    end else if (half_tick) begin
                        phase <= ~phase;
                        if (phase) begin
                            decided[idx] <= comp; // R1
                            last_bit     <= comp;
                            if (idx == 4'd0) begin
                                state <= SCC_IDLE;
                            end else begin
                                idx <= idx - 4'd1;
                            end
                        end
                    end
                end
                default: state <= SCC_IDLE;
            endcase
        end
    end

    // Undecided bits of a cut-short conversion copy the last decided bit
    always_comb begin
        next_result = decided;
        for (int i = 0; i < RES_BITS; i++) begin
            if (state != SCC_BITS || i <= int'(idx)) begin
                next_result[i] = last_bit;
            end
        end
        if (finishing) begin
            next_result    = decided;
            next_result[0] = comp;
        end
        next_trial = RST_RES;
        if (state == SCC_BITS) begin
            next_trial = decided | (10'h001 << idx);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done   <= 1'b0;
            result <= RST_RES;
        end else begin
            done <= finishing || (busy && abort);
            if (finishing || (busy && abort)) begin
                result <= next_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trial  <= RST_RES;
            sample <= 1'b0;
        end else begin
            trial  <= next_trial;
            sample <= (state == SCC_ACQ);
        end
    end

endmodule : scc_sar_engine

// ### verif/scc_converter_control_sva.sv
// Port checker for the converter control block
`timescale 1ns/100ps
module scc_sva (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        AVS_READ,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        CORE_SLEEP,
    input wire logic        CONV_POWER,
    input wire logic        SAMPLE_HOLD,
    input wire logic [6:0]  CHANNEL_ROUTE,
    input wire logic        TEMP_RANGE_HIGH,
    input wire logic        WAKE_REQ,
    input wire logic        WAKE_TO_ISR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wait_first_a:
        assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST) else $error("a");
    one_wait_a:
        assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("b");
    rd_upper_a:
        assert property (AVS_READ && !AVS_WAITREQUEST |->
        AVS_READDATA[31:8] == 24'h0) else $error("c");
    route_a:
        assert property ($onehot0(CHANNEL_ROUTE)) else $error("d");
    power_a:
        assert property ($rose(SAMPLE_HOLD) |-> CONV_POWER) else $error("e");
    wake_a:
        assert property (WAKE_REQ |-> CORE_SLEEP ##1 !WAKE_REQ) else $error("f");
    isr_a:
        assert property ($fell(CORE_SLEEP) |=> !WAKE_TO_ISR) else $error("g");
    range_a:
        assert property (!$stable(TEMP_RANGE_HIGH) |-> $past(AVS_READ, 1) ||
        !$past(AVS_WAITREQUEST) || !$past(AVS_WAITREQUEST, 2)) else $error("h");
    cover property ($rose(SAMPLE_HOLD));
    cover property (WAKE_REQ);
    cover property ($fell(CORE_SLEEP));
endmodule : scc_sva
bind scc_converter_control scc_sva i_sva (.CLK(CLK), .RST(RST),
    .AVS_READ(AVS_READ), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_READDATA(AVS_READDATA), .CORE_SLEEP(CORE_SLEEP),
    .CONV_POWER(CONV_POWER), .SAMPLE_HOLD(SAMPLE_HOLD),
    .CHANNEL_ROUTE(CHANNEL_ROUTE), .TEMP_RANGE_HIGH(TEMP_RANGE_HIGH),
    .WAKE_REQ(WAKE_REQ), .WAKE_TO_ISR(WAKE_TO_ISR));

// ### verif/test_sar_converter_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module test_sar_converter_control;
    import scc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        sleep = 1'b0;
    logic        comp = 1'b0;
    logic [2:0]  rc = 3'h0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [9:0]  vin = 10'h0;
    logic [31:0] rdat, last;
    logic        wait_req, pin_ref, ts_pwr, ts_rng, irq, wake, isr;
    logic [9:0]  trial;
    logic [6:0]  route;
    logic [7:0]  d;
    logic [32:0] n;
    logic [32:0] notes[$];
    int          err_count = 0;
    int          samples_checked = 0;
    scc_converter_control i_scc_converter_control (.CLK(clk), .RST(rst),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req), .CORE_SLEEP(sleep), .RC_OSC_IN(rc[2]),
        .COMP_OUT(comp), .CONV_POWER(), .SAMPLE_HOLD(), .TRIAL_CODE(trial),
        .CHANNEL_ROUTE(route), .REF_FROM_PIN(pin_ref),
        .TEMP_SENSE_POWER(ts_pwr), .TEMP_RANGE_HIGH(ts_rng),
        .FIXED_REF_POWER(), .COMP_REF_GAIN(), .CONV_REF_GAIN(),
        .CONV_IRQ(irq), .WAKE_REQ(wake), .WAKE_TO_ISR(isr));
    always #5 clk = ~clk;
    always @(posedge clk) rc <= rc + 3'h1;
    // Ideal comparator; the design resynchronises it
    always @(posedge clk) comp <= (vin >= trial);
    always @(posedge clk) begin
        if (rd && !wait_req) begin
            n = notes.pop_front();
            if (n[32]) check(rdat, n[31:0]);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Extra edge first so back-to-back calls never drive twice at one edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] v, input logic [32:0] note);
        @(posedge clk);
        if (!w) notes.push_back(note);
        adr <= a;
        wdat <= {24'h0, v};
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wait_req);
        last = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic convert(input logic fm);
        vin = 10'($urandom);
        bus(1, OFS_CTRL1, {fm, CS_DIV64, 4'h2}, '0);
        bus(1, OFS_CTRL0, {1'b0, CH_FVR, 2'b01}, '0);
        repeat (8) @(posedge clk);
        bus(1, OFS_CTRL0, {1'b0, CH_FVR, 2'b11}, '0);
        do bus(0, OFS_CTRL0, 0, '0); while (last[CTRL0_GO]);
        bus(0, OFS_RES_HI, 0, {9'h100, 16'h0,
            fm ? {6'h0, vin[9:8]} : vin[9:2]});
        bus(0, OFS_RES_LO, 0, {9'h100, 16'h0,
            fm ? vin[7:0] : {vin[1:0], 6'h0}});
        bus(0, OFS_FLAGS, 0, {1'b1, 32'h40});
        check(32'(pin_ref), 32'h1);
    endtask : convert
    task automatic conclude;
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        #400us;
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(56));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(1, 4'h9, 8'hff, '0);
        for (int a = 0; a < 16; a++) bus(0, 4'(a), 0, {1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            d = {3'h0, i[2] ? 5'h1c + 5'(i[1:0]) : 5'(i)};
            bus(1, OFS_CTRL0, {1'b0, d[4:0], 2'b01}, '0);
            repeat (3) @(posedge clk);
            check(32'(route), i == 4 ? 0 : 32'h1 << (i - (i > 4)));
        end
        d = 8'($urandom) & 8'hbf;
        bus(1, OFS_VREF, d, '0);
        bus(0, OFS_VREF, 0, {9'h100, 16'h0, d | {1'b0, d[7], 6'h0}});
        check({30'h0, ts_pwr, ts_rng}, {30'h0, d[5:4]});
        convert(1'b1);
        check(32'(irq), 32'h0);
        bus(1, OFS_ENABLES, 8'h40, '0);
        bus(1, OFS_INTCTL, 8'hc0, '0);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1);
        bus(1, OFS_FLAGS, 8'h00, '0);
        bus(0, OFS_FLAGS, 0, {1'b1, 32'h0});
        convert(1'b0);
        check(32'(irq), 32'h1);
        bus(1, OFS_INTCTL, 8'h40, '0);
        bus(1, OFS_CTRL1, 8'h30, '0);
        bus(1, OFS_CTRL0, {1'b0, CH_TEMP, 2'b01}, '0);
        #200us;
        bus(1, OFS_CTRL0, {1'b0, CH_TEMP, 2'b11}, '0);
        sleep <= 1'b1;
        while (!wake) @(posedge clk);
        check(32'(isr), 32'h0);
        sleep <= 1'b0;
        conclude();
    end
endmodule : test_sar_converter_control
